// [core/smoke_alarm_sequencer.sv]
// Control sequencer for an ionization smoke alarm
`timescale 1ns/1ps
`include "smoke_cfg.svh"
// What this block does
// - Idle timebase 1.65 s, strobe sensing each period
// - Skip smoke check during LED, chirp, local-smoke horn
// - Battery check every 24 timebase cycles
// - Smoke shortens timebase to 41.67 ms, horn on
// - Alarm horn 500 ms on, 500 ms off
// - Recheck smoke in horn-off, stop if clear
// - Local smoke: no battery alarm, LED 1 Hz
// - Remote smoke: LED pulsing suppressed too
// - Local smoke drives interconnect line
// - Interconnect disabled three cycles after power-up
// - Test low: comparator output follows smoke continuously
// - Each sensing strobe lasts about 10 ms
// - LED pulse 11.6 ms every 40 s, battery checked
// - Smoke selects more sensitive threshold, hysteresis
// - Alarm ends only during horn-off interval
// - Smoke comparator strobed at most once per timebase cycle
module smoke_alarm_sequencer
(
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic smoke_cmp,
   input  wire logic bat_low_cmp,
   input  wire logic test_n,
   input  wire logic io_in,
   output logic      io_out,
   output logic      io_oe,
   output logic      strobe,
   output logic      cmp_out,
   output logic      horn_en,
   output logic      led_on,
   output logic      sens_high
);
   localparam smoke_pkg::cnt_t TB_IDLE_CYC  = 26'(`US_TO_CYC(`TB_IDLE_US));
   localparam smoke_pkg::cnt_t TB_SMOKE_CYC = 26'(`US_TO_CYC(`TB_SMOKE_US));
   localparam smoke_pkg::cnt_t HORN_CYC     = 26'(`US_TO_CYC(`HORN_HALF_US));
   localparam smoke_pkg::cnt_t STROBE_CYC   = 26'(`US_TO_CYC(`STROBE_US));
   localparam smoke_pkg::cnt_t LED_CYC      = 26'(`US_TO_CYC(`LED_PULSE_US));
   localparam smoke_pkg::cnt_t LED1HZ_CYC   = 26'(`US_TO_CYC(`LED_SMOKE_US));
   localparam logic [4:0] BAT_N  = 5'(`BAT_EVERY_CYC);
   localparam logic [1:0] IO_N   = 2'(`IO_HOLD_CYC);
   localparam logic [5:0] LED_TB = 6'((`LED_PERIOD_S * 1000000) / `TB_IDLE_US);

   typedef struct packed {
      smoke_pkg::mode_e mode;
      smoke_pkg::cnt_t  tb;
      smoke_pkg::cnt_t  horn;
      smoke_pkg::cnt_t  led1hz;
      logic             horn_ph;
      logic [4:0]       bat_cnt;
      logic [5:0]       led_cnt;
      logic [1:0]       io_cnt;
      logic             bat_bad;
      logic             io_out;
      logic             io_oe;
      logic             strobe;
      logic             cmp_out;
      logic             horn_en;
      logic             led_on;
      logic             sens_high;
   } state_s;

   state_s st_q;
   state_s st_d;
   logic   smoke_s;
   logic   bat_s;
   logic   test_s;
   logic   io_s;
   logic   tb_tick;
   logic   strb_busy;
   logic   led_busy;
   logic   chirp_busy;
   logic   strb_go;
   logic   led_go;
   logic   chirp_go;
   logic   strb_busy_q;

   sync2 u_sy_smoke (.sys_clk(sys_clk), .arst_n(arst_n), .pin_in(smoke_cmp),   .pin_sync(smoke_s));
   sync2 u_sy_bat   (.sys_clk(sys_clk), .arst_n(arst_n), .pin_in(bat_low_cmp), .pin_sync(bat_s));
   sync2 u_sy_test  (.sys_clk(sys_clk), .arst_n(arst_n), .pin_in(test_n),      .pin_sync(test_s));
   sync2 u_sy_io    (.sys_clk(sys_clk), .arst_n(arst_n), .pin_in(io_in),       .pin_sync(io_s));

   pulse_timer u_strobe (.sys_clk(sys_clk), .arst_n(arst_n), .load(strb_go),
                         .load_val(STROBE_CYC), .busy(strb_busy));
   pulse_timer u_led    (.sys_clk(sys_clk), .arst_n(arst_n), .load(led_go),
                         .load_val(LED_CYC), .busy(led_busy));
   pulse_timer u_chirp  (.sys_clk(sys_clk), .arst_n(arst_n), .load(chirp_go),
                         .load_val(26'(`US_TO_CYC(`CHIRP_US))), .busy(chirp_busy));

   function automatic logic in_alarm(input smoke_pkg::mode_e m);
      return m != smoke_pkg::MODE_IDLE;
   endfunction

   assign tb_tick = (st_q.tb == '0);

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         strb_busy_q <= 1'b0;
      else
         strb_busy_q <= strb_busy;
   end

   always_comb
   begin
      logic busy_period;
      logic led_pulse;
      logic sample;
      busy_period = 1'b0;
      led_pulse   = 1'b0;
      sample      = 1'b0;
      st_d        = st_q;
      strb_go     = 1'b0;
      led_go      = 1'b0;
      chirp_go    = 1'b0;

      // Timebase period follows alarm mode
      st_d.tb = tb_tick ? (in_alarm(st_q.mode) ? TB_SMOKE_CYC : TB_IDLE_CYC) - 26'h0000001
                        : st_q.tb - 26'h0000001;

      if (tb_tick)
      begin
         if (st_q.io_cnt != IO_N)
            st_d.io_cnt = st_q.io_cnt + 2'h1;
         if (!in_alarm(st_q.mode))
         begin
            led_pulse = (st_q.led_cnt == LED_TB - 6'h01);
            st_d.led_cnt = led_pulse ? 6'h00 : st_q.led_cnt + 6'h01;
            if (led_pulse)
            begin
               led_go = 1'b1;
               if (st_q.bat_bad)
                  chirp_go = 1'b1;
            end
            // Battery evaluated every 24 cycles and at each LED pulse
            if (st_q.bat_cnt == BAT_N - 5'h01)
               st_d.bat_cnt = 5'h00;
            else
               st_d.bat_cnt = st_q.bat_cnt + 5'h01;
         end
         busy_period = led_pulse || led_busy || chirp_busy ||
                       (st_q.mode == smoke_pkg::MODE_LOCAL && st_q.horn_ph);
         if (!busy_period)
            strb_go = 1'b1;
      end
      if (led_busy && !in_alarm(st_q.mode) && bat_s && st_q.bat_cnt == 5'h00)
         st_d.bat_bad = 1'b1;
      else if (led_busy && !bat_s)
         st_d.bat_bad = 1'b0;

      sample = (strb_busy_q && !strb_busy) || !test_s;

      // Horn modulation, self-completing
      if (in_alarm(st_q.mode))
      begin
         if (st_q.horn == '0)
         begin
            st_d.horn    = HORN_CYC - 26'h0000001;
            st_d.horn_ph = !st_q.horn_ph;
         end
         else
            st_d.horn = st_q.horn - 26'h0000001;
      end

      unique case (st_q.mode)
         smoke_pkg::MODE_IDLE:
         begin
            if (sample && smoke_s)
            begin
               st_d.mode    = smoke_pkg::MODE_LOCAL;
               st_d.horn    = HORN_CYC - 26'h0000001;
               st_d.horn_ph = 1'b1;
               st_d.led1hz  = LED1HZ_CYC - 26'h0000001;
               st_d.bat_bad = 1'b0;
            end
            // Listening on the line is allowed at once; only driving it waits out the hold
            else if (io_s)
            begin
               st_d.mode    = smoke_pkg::MODE_REMOTE;
               st_d.horn    = HORN_CYC - 26'h0000001;
               st_d.horn_ph = 1'b1;
            end
         end
         smoke_pkg::MODE_LOCAL:
         begin
            // Smoke recheck only while the horn is off
            if (sample && !st_q.horn_ph && !smoke_s)
               st_d.mode = smoke_pkg::MODE_IDLE;
            st_d.led1hz = (st_q.led1hz == '0) ? LED1HZ_CYC - 26'h0000001
                                              : st_q.led1hz - 26'h0000001;
            if (st_q.led1hz == '0)
               led_go = 1'b1;
         end
         smoke_pkg::MODE_REMOTE:
         begin
            if (sample && smoke_s)
               st_d.mode = smoke_pkg::MODE_LOCAL;
            else if (!io_s && !st_q.horn_ph)
               st_d.mode = smoke_pkg::MODE_IDLE;
         end
      endcase

      st_d.io_oe     = (st_q.mode == smoke_pkg::MODE_LOCAL) && (st_q.io_cnt == IO_N);
      st_d.io_out    = st_d.io_oe;
      st_d.strobe    = strb_busy && test_s;
      st_d.cmp_out   = !test_s ? smoke_s : (sample ? smoke_s : st_q.cmp_out);
      st_d.horn_en   = (in_alarm(st_q.mode) && st_q.horn_ph) || chirp_busy;
      st_d.led_on    = led_busy && st_q.mode != smoke_pkg::MODE_REMOTE;
      st_d.sens_high = (st_d.mode == smoke_pkg::MODE_LOCAL);
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         st_q <= '{mode: smoke_pkg::MODE_IDLE, default: '0};
      else
         st_q <= st_d;
   end

   assign io_out    = st_q.io_out;
   assign io_oe     = st_q.io_oe;
   assign strobe    = st_q.strobe;
   assign cmp_out   = st_q.cmp_out;
   assign horn_en   = st_q.horn_en;
   assign led_on    = st_q.led_on;
   assign sens_high = st_q.sens_high;

   sequence local_exit_s;
      (st_q.mode == smoke_pkg::MODE_LOCAL) ##1 (st_q.mode == smoke_pkg::MODE_IDLE);
   endsequence

   io_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_q.io_cnt != IO_N) |-> !io_oe)
      else $error("interconnect driven before hold ended");
   io_local_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_q.mode == smoke_pkg::MODE_LOCAL && st_q.io_cnt == IO_N) |=> io_oe)
      else $error("local smoke not driving interconnect");
   remote_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_q.mode == smoke_pkg::MODE_REMOTE) |=> !io_oe || $past(st_q.mode) != smoke_pkg::MODE_REMOTE)
      else $error("remote alarm drove interconnect");
   led_remote_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_q.mode == smoke_pkg::MODE_REMOTE) |=> !led_on)
      else $error("led pulsed in remote alarm");
   alarm_end_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      local_exit_s |-> $past(!st_q.horn_ph))
      else $error("alarm ended during horn on");
   strobe_test_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !test_s |=> !strobe)
      else $error("strobe raised in test mode");
   led_local_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_q.mode == smoke_pkg::MODE_LOCAL && st_q.led1hz == '0) |=> ##1 led_on)
      else $error("led not pulsed in local smoke");
   chirp_horn_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      chirp_busy |=> horn_en)
      else $error("chirp did not sound horn");
   strobe_skip_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (tb_tick && (led_busy || chirp_busy)) |-> !strb_go)
      else $error("smoke check during led or chirp");
   idle_tb_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (!in_alarm(st_q.mode) && tb_tick) |=> (st_q.tb == TB_IDLE_CYC - 26'h0000001))
      else $error("idle timebase wrong");
   sens_alarm_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_q.mode == smoke_pkg::MODE_LOCAL) |-> sens_high)
      else $error("threshold not raised in smoke");
   test_cmp_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !test_s |=> (cmp_out == $past(smoke_s)))
      else $error("test mode comparator mismatch");
   smoke_tb_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (in_alarm(st_q.mode) && tb_tick) |=> (st_q.tb == TB_SMOKE_CYC - 26'h0000001))
      else $error("smoke timebase wrong");
   horn_mod_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (in_alarm(st_q.mode) && st_q.horn_ph) |=> ##1 horn_en || !in_alarm(st_q.mode) || !st_q.horn_ph)
      else $error("horn not sounding in on interval");
endmodule

// [pkg/smoke_cfg.svh]
// Timing and count constants for the smoke alarm sequencer
`ifndef SMOKE_CFG_SVH
`define SMOKE_CFG_SVH
`define CLK_HZ          25000000
`define CLK_PERIOD_NS   40
`define TB_IDLE_US      1650000
`define TB_SMOKE_US     41670
`define HORN_HALF_US    500000
`define STROBE_US       10000
`define LED_PULSE_US    11600
`define LED_PERIOD_S    40
`define LED_SMOKE_US    1000000
`define BAT_EVERY_CYC   24
`define IO_HOLD_CYC     3
`define CHIRP_US        11600
`define US_TO_CYC(t)    (((t) * 1000) / `CLK_PERIOD_NS)
`endif

// [pkg/smoke_pkg.sv]
// Types shared by the smoke alarm sequencer
package smoke_pkg;
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_LOCAL,
      MODE_REMOTE
   } mode_e;
   typedef logic [25:0] cnt_t;
endpackage

// [core/sync2.sv]
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module sync2
(
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic pin_in,
   output logic      pin_sync
);
   logic meta_q;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_q   <= 1'b0;
         pin_sync <= 1'b0;
      end
      else
      begin
         meta_q   <= pin_in;
         pin_sync <= meta_q;
      end
   end
endmodule

// [core/pulse_timer.sv]
// Loadable down counter that drops busy when it reaches zero
`timescale 1ns/1ps
module pulse_timer
(
   input  wire logic            sys_clk,
   input  wire logic            arst_n,
   input  wire logic            load,
   input  wire smoke_pkg::cnt_t load_val,
   output logic                 busy
);
   smoke_pkg::cnt_t cnt_q;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q <= '0;
         busy  <= 1'b0;
      end
      else if (load)
      begin
         cnt_q <= load_val;
         busy  <= 1'b1;
      end
      else if (cnt_q != '0)
      begin
         cnt_q <= cnt_q - 26'h0000001;
         busy  <= (cnt_q != 26'h0000001);
      end
      else
      begin
         busy <= 1'b0;
      end
   end
endmodule

// [verif/remote_unit.sv]
// Model of another alarm unit sharing the interconnect line
`timescale 1ns/1ps
module remote_unit
(
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic alarm_req,
   input  wire logic io_out,
   input  wire logic io_oe,
   output logic      line,
   output logic      remote_seen
);
   // Line has a current sink, so it reads low unless some unit drives it
   assign line = (io_oe & io_out) | alarm_req;
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         remote_seen <= 1'b0;
      else
         remote_seen <= io_oe & io_out;
   end
endmodule

// [verif/smoke_alarm_sequencer_tb.sv]
// Self-checking bench for the smoke alarm sequencer
`timescale 1ns/1ps
module smoke_alarm_sequencer_tb;
   logic sys_clk, arst_n, smoke_cmp, bat_low_cmp, test_n, alarm_req;
   logic io_in, io_out, io_oe, strobe, cmp_out, horn_en, led_on, sens_high, remote_seen;
   int   err_count;
   int   n_checks;

   smoke_alarm_sequencer smoke_alarm_sequencer_i
   (
      .sys_clk     (sys_clk),
      .arst_n      (arst_n),
      .smoke_cmp   (smoke_cmp),
      .bat_low_cmp (bat_low_cmp),
      .test_n      (test_n),
      .io_in       (io_in),
      .io_out      (io_out),
      .io_oe       (io_oe),
      .strobe      (strobe),
      .cmp_out     (cmp_out),
      .horn_en     (horn_en),
      .led_on      (led_on),
      .sens_high   (sens_high)
   );

   remote_unit remote_unit_i
   (
      .sys_clk     (sys_clk),
      .arst_n      (arst_n),
      .alarm_req   (alarm_req),
      .io_out      (io_out),
      .io_oe       (io_oe),
      .line        (io_in),
      .remote_seen (remote_seen)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic act, input logic exp, input string msg);
      n_checks++;
      if (act !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   // Waits on one output: 0 cmp_out, 1 horn_en
   task automatic wait_out(input int which, input logic val, input int bound);
      logic cur;
      for (int i = 0; i < bound; i++)
      begin
         @(negedge sys_clk);
         cur = (which == 0) ? cmp_out : horn_en;
         if (cur === val)
            return;
      end
      err_count++;
      $display("mismatch at %0t: wait on output %0d ran out", $time, which);
      summarize();
   endtask

   // Runs n cycles; flags io_oe or led_on ever high, and horn_en ever not high
   task automatic watch(input int n, output logic oe_seen, output logic led_seen, output logic horn_low);
      oe_seen = 1'b0;
      led_seen = 1'b0;
      horn_low = 1'b0;
      repeat (n)
      begin
         @(negedge sys_clk);
         oe_seen = oe_seen | (io_oe !== 1'b0);
         led_seen = led_seen | (led_on !== 1'b0);
         horn_low = horn_low | (horn_en !== 1'b1);
      end
   endtask

   task automatic do_reset();
      @(negedge sys_clk);
      arst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(horn_en | io_oe | led_on | strobe | cmp_out | sens_high, 1'b0, "outputs active in reset");
      arst_n = 1'b1;
   endtask

   task automatic sc_idle();
      logic oe, led, hl;
      test_n = 1'b1;
      smoke_cmp = 1'b0;
      alarm_req = 1'b0;
      do_reset();
      repeat (5) @(negedge sys_clk);
      chk(strobe, 1'b1, "no sensing strobe on first timebase tick");
      watch(4000, oe, led, hl);
      chk(strobe, 1'b1, "sensing strobe ended early");
      chk(hl, 1'b1, "horn sounded without smoke");
      chk(oe, 1'b0, "line driven without smoke");
      chk(sens_high, 1'b0, "sensitive threshold without smoke");
   endtask

   task automatic sc_local();
      logic oe, led, hl;
      test_n = 1'b0;
      smoke_cmp = 1'b1;
      do_reset();
      wait_out(0, 1'b1, 20);
      wait_out(1, 1'b1, 20);
      @(negedge sys_clk);
      chk(sens_high, 1'b1, "threshold not raised in smoke");
      watch(5000, oe, led, hl);
      chk(oe, 1'b0, "line driven soon after power-up");
      chk(hl, 1'b0, "horn broke its on phase");
      smoke_cmp = 1'b0;
      wait_out(0, 1'b0, 20);
      watch(5000, oe, led, hl);
      chk(hl, 1'b0, "alarm ended inside horn on phase");
      chk(remote_seen, 1'b0, "remote unit saw smoke too early");
   endtask

   task automatic sc_remote();
      logic oe, led, hl;
      test_n = 1'b0;
      smoke_cmp = 1'b0;
      do_reset();
      alarm_req = 1'b1;
      wait_out(1, 1'b1, 300);
      watch(5000, oe, led, hl);
      chk(oe, 1'b0, "line driven on remote smoke");
      chk(led, 1'b0, "LED pulsed on remote smoke");
      chk(cmp_out, 1'b0, "comparator shows smoke on remote alarm");
      alarm_req = 1'b0;
   endtask

   initial
   begin
      err_count = 0;
      n_checks = 0;
      arst_n = 1'b0;
      smoke_cmp = 1'b0;
      bat_low_cmp = 1'b1;
      test_n = 1'b1;
      alarm_req = 1'b0;
      repeat (2) @(negedge sys_clk);
      arst_n = 1'b1;
      sc_idle();
      sc_local();
      sc_remote();
      summarize();
   end
endmodule
